// [core/lmsc_config_bank.sv]
// line mode, receive sensitivity and master clock selection bank
`timescale 1ns/100ps
// Function
// - pll on, family set: codes map to 1.544, 3.088, 6.176, 12.352 MHz
// - pll on, family clear: codes map to 2.048, 4.096, 8.192, 16.384 MHz
// - each haul bit enables long haul for its channel's transmitter
// - haul registers at 07h and 27h, eight bits, reset zero
// - set ratio bit selects 1:1 receive transformer for its channel
// - channels 1-6 and 9-12 each have a three bit sensitivity and monitor gain code
// - odd channel code bits 2-0, ratio bit 3; even bits 6-4, ratio 7
// - pairs 3-4, 5-6 follow 08h; upper copies at 28h and 29h
// - pll on bit enables the loop; clear applies master clock directly
// - family bit picks 1.544 or 2.048 MHz multiples with period select
module lmsc_config_bank
(
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // host register port
    input  wire lmsc_pkg::lmsc_req_t     hostReq,
    output logic [7:0]                   hostRdData,
    output logic                         hostRdValid,
    // master clock control settings
    input  wire lmsc_pkg::lmsc_clk_cfg_t clkCfg,
    // decoded configuration
    output lmsc_pkg::lmsc_chan_t         chanCfg,
    output lmsc_pkg::lmsc_clk_sel_t      clkSel
);
    import lmsc_pkg::*;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------

    // maps an offset to a register index and a hit flag
    function automatic logic [3:0] decode_offset(input logic [7:0] off);
        logic [3:0] res;
        res = 4'h0;
        unique case (off)
            OFF_HAUL_LOW:     res = {1'b1, IDX_HAUL_LOW};
            OFF_SENSE_A_LOW:  res = {1'b1, IDX_SENSE_A_LOW};
            OFF_SENSE_B_LOW:  res = {1'b1, IDX_SENSE_B_LOW};
            OFF_SENSE_C_LOW:  res = {1'b1, IDX_SENSE_C_LOW};
            OFF_HAUL_HIGH:    res = {1'b1, IDX_HAUL_HIGH};
            OFF_SENSE_A_HIGH: res = {1'b1, IDX_SENSE_A_HIGH};
            OFF_SENSE_B_HIGH: res = {1'b1, IDX_SENSE_B_HIGH};
            default:          res = 4'h0;
        endcase
        return res;
    endfunction

    logic [3:0] decoded;
    logic       addrHit;
    logic [2:0] addrIdx;
    logic       writeHit;

    assign decoded  = decode_offset(hostReq.addr);
    assign addrHit  = decoded[3];
    assign addrIdx  = decoded[2:0];
    assign writeHit = hostReq.wr & addrHit;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] regs_q [NUM_REGS];

    // one write-enabled byte per register; reads never touch the store
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++)
        begin : g_reg
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                    regs_q[gi] <= REG_RESET;
                else if (writeHit && (addrIdx == 3'(gi)))
                    regs_q[gi] <= hostReq.wdata;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rdData_d;
    logic [7:0] rdData_q;
    logic       rdValid_q;

    assign rdData_d = addrHit ? regs_q[addrIdx] : UNMAPPED_READ;

    // read data registered one cycle after the read strobe
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdValid_q <= hostReq.rd;
            if (hostReq.rd)
                rdData_q <= rdData_d;
        end
    end

    assign hostRdData  = rdData_q;
    assign hostRdValid = rdValid_q;

    // ----------------------------------------------------------------
    // per-channel fields
    // ----------------------------------------------------------------
    logic [7:0] senseRegs [8];

    // sensitivity registers in channel-pair order; the fourth pair of each bank and the upper third pair
    // have no store in this bank and read as zero for channels 7-8 and 13-16
    assign senseRegs[0] = regs_q[IDX_SENSE_A_LOW];
    assign senseRegs[1] = regs_q[IDX_SENSE_B_LOW];
    assign senseRegs[2] = regs_q[IDX_SENSE_C_LOW];
    assign senseRegs[3] = 8'h00;
    assign senseRegs[4] = regs_q[IDX_SENSE_A_HIGH];
    assign senseRegs[5] = regs_q[IDX_SENSE_B_HIGH];
    assign senseRegs[6] = 8'h00;
    assign senseRegs[7] = 8'h00;

    // haul bit n drives channel n+1 (low) or n+9 (high)
    assign chanCfg.longHaul = {regs_q[IDX_HAUL_HIGH], regs_q[IDX_HAUL_LOW]};

    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pair
            // odd channel in low nibble, even channel in high nibble
            assign chanCfg.rxRatio1to1[2*gi]   = senseRegs[gi][ODD_RATIO_BIT];
            assign chanCfg.rxRatio1to1[2*gi+1] = senseRegs[gi][EVEN_RATIO_BIT];
            assign chanCfg.rxSensitivityCode[6*gi +: 3] =
                senseRegs[gi][ODD_CODE_LSB +: 3];
            assign chanCfg.rxSensitivityCode[6*gi+3 +: 3] =
                senseRegs[gi][EVEN_CODE_LSB +: 3];
        end
    endgenerate

    // ----------------------------------------------------------------
    // master clock selection decode
    // ----------------------------------------------------------------
    logic [14:0] familyBase;
    logic [14:0] pllKhz;
    logic [14:0] directKhz;

    assign familyBase = clkCfg.clockFamilySelect ? KHZ_T1_BASE : KHZ_E1_BASE;
    assign pllKhz     = familyBase << clkCfg.clockPeriodSelect;
    assign directKhz  = clkCfg.mclkIsE1Rate ? KHZ_E1_BASE : KHZ_T1_BASE;

    // with the loop off the period and family bits are ignored
    assign clkSel.pllActive = clkCfg.pllOn;
    assign clkSel.mclkKhz   = clkCfg.pllOn ? pllKhz : directKhz;
    assign clkSel.mode      = clkCfg.pllOn ? LMSC_MODE_EITHER :
                              (clkCfg.mclkIsE1Rate ? LMSC_MODE_E1 : LMSC_MODE_T1);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_write_low_haul;
        hostReq.wr && hostReq.addr == OFF_HAUL_LOW;
    endsequence

    haul_low_store_a: assert property (
        s_write_low_haul |=> chanCfg.longHaul[7:0] == $past(hostReq.wdata))
        else $error("low haul register did not store write data");

    haul_high_store_a: assert property (
        hostReq.wr && hostReq.addr == OFF_HAUL_HIGH
        |=> chanCfg.longHaul[15:8] == $past(hostReq.wdata))
        else $error("high haul bits do not follow write");

    pair_a_fields_a: assert property (
        hostReq.wr && hostReq.addr == OFF_SENSE_A_LOW
        |=> chanCfg.rxSensitivityCode[2:0] == $past(hostReq.wdata[2:0])
            && chanCfg.rxRatio1to1[1] == $past(hostReq.wdata[7]))
        else $error("channel pair one fields misplaced");

    upper_pair_fields_a: assert property (
        hostReq.wr && hostReq.addr == OFF_SENSE_B_HIGH
        |=> chanCfg.rxSensitivityCode[35:33] == $past(hostReq.wdata[6:4])
            && chanCfg.rxRatio1to1[10] == $past(hostReq.wdata[3]))
        else $error("channels eleven and twelve fields misplaced");

    ratio_c_field_a: assert property (
        hostReq.wr && hostReq.addr == OFF_SENSE_C_LOW
        |=> chanCfg.rxRatio1to1[4] == $past(hostReq.wdata[3])
            && chanCfg.rxSensitivityCode[17:15] == $past(hostReq.wdata[6:4]))
        else $error("channel five or six field misplaced");

    sequence s_read_mapped;
        hostReq.rd && !hostReq.wr && addrHit;
    endsequence

    readback_match_a: assert property (
        s_read_mapped
        |=> hostRdValid && hostRdData == $past(regs_q[addrIdx]))
        else $error("read data differs from stored value");

    read_no_effect_a: assert property (
        hostReq.rd && !hostReq.wr
        |=> chanCfg == $past(chanCfg))
        else $error("read altered configuration");

    unmapped_zero_a: assert property (
        hostReq.rd && !addrHit |=> hostRdData == UNMAPPED_READ)
        else $error("unmapped read not zero");

    pll_family_t1_a: assert property (
        clkCfg.pllOn && clkCfg.clockFamilySelect && clkCfg.clockPeriodSelect == 2'b11
        |-> clkSel.mclkKhz == 15'h3040 && clkSel.mode == LMSC_MODE_EITHER)
        else $error("family set code three not 12352 kHz");

    pll_family_e1_a: assert property (
        clkCfg.pllOn && !clkCfg.clockFamilySelect && clkCfg.clockPeriodSelect == 2'b01
        |-> clkSel.mclkKhz == 15'h1000)
        else $error("family clear code one not 4096 kHz");

    pll_off_direct_a: assert property (
        !clkCfg.pllOn
        |-> clkSel.mclkKhz == (clkCfg.mclkIsE1Rate ? 15'h0800 : 15'h0608)
            && !clkSel.pllActive
            && clkSel.mode == (clkCfg.mclkIsE1Rate ? LMSC_MODE_E1 : LMSC_MODE_T1))
        else $error("direct master clock decode wrong");

    // ----------------------------------------------------------------
    // further checks on the register map and clock decode
    // ----------------------------------------------------------------

    // strobe conditions reused by the checks below
    sequence s_write_unmapped;
        hostReq.wr && !addrHit;
    endsequence

    sequence s_idle_read;
        !hostReq.rd;
    endsequence

    sequence s_idle_write;
        !hostReq.wr;
    endsequence

    // second pair of the low bank: channels three and four
    pair_b_fields_a: assert property (
        hostReq.wr && hostReq.addr == OFF_SENSE_B_LOW
        |=> chanCfg.rxSensitivityCode[8:6] == $past(hostReq.wdata[2:0])
            && chanCfg.rxRatio1to1[3] == $past(hostReq.wdata[7]))
        else $error("channels three and four fields misplaced");

    // first pair of the high bank: channels nine and ten
    pair_a_high_fields_a: assert property (
        hostReq.wr && hostReq.addr == OFF_SENSE_A_HIGH
        |=> chanCfg.rxSensitivityCode[26:24] == $past(hostReq.wdata[2:0])
            && chanCfg.rxRatio1to1[9] == $past(hostReq.wdata[7]))
        else $error("channels nine and ten fields misplaced");

    // channels without a store in this bank always show zero
    unstored_zero_a: assert property (
        chanCfg.rxSensitivityCode[23:18] == 6'h00
        && chanCfg.rxSensitivityCode[47:36] == 12'h000
        && chanCfg.rxRatio1to1[7:6] == 2'h0
        && chanCfg.rxRatio1to1[15:12] == 4'h0)
        else $error("unstored channel fields not zero");

    // a write to an unmapped offset leaves every field alone
    unmapped_write_a: assert property (
        s_write_unmapped |=> chanCfg == $past(chanCfg))
        else $error("unmapped write changed configuration");

    // haul bits move only on a write
    haul_hold_a: assert property (
        s_idle_write |=> chanCfg.longHaul == $past(chanCfg.longHaul))
        else $error("haul bits changed without a write");

    // valid follows the read strobe by exactly one cycle
    read_valid_pulse_a: assert property (
        hostReq.rd |=> hostRdValid)
        else $error("read valid missing after read strobe");

    read_valid_drop_a: assert property (
        s_idle_read |=> !hostRdValid)
        else $error("read valid without a read strobe");

    // read data stands until the next read
    read_data_hold_a: assert property (
        s_idle_read |=> $stable(hostRdData))
        else $error("read data changed without a read");

    // loop on: mode is either and the loop shows active
    pll_on_mode_a: assert property (
        clkCfg.pllOn |-> clkSel.pllActive && clkSel.mode == LMSC_MODE_EITHER)
        else $error("loop on but mode or activity wrong");

    // family set, code zero: base rate of the 1.544 family
    family_set_base_a: assert property (
        clkCfg.pllOn && clkCfg.clockFamilySelect && clkCfg.clockPeriodSelect == 2'b00
        |-> clkSel.mclkKhz == 15'h0608)
        else $error("family set code zero not 1544 kHz");

    // family clear, code three: top rate of the 2.048 family
    family_clear_top_a: assert property (
        clkCfg.pllOn && !clkCfg.clockFamilySelect && clkCfg.clockPeriodSelect == 2'b11
        |-> clkSel.mclkKhz == 15'h4000)
        else $error("family clear code three not 16384 kHz");

endmodule

// [core/lmsc_pkg.sv]
// package for the line mode and sensitivity configuration bank
package lmsc_pkg;

    // ----------------------------------------------------------------
    // register offsets and layout
    // ----------------------------------------------------------------
    localparam int unsigned NUM_REGS          = 7;
    localparam logic [7:0]  OFF_HAUL_LOW      = 8'h07;
    localparam logic [7:0]  OFF_SENSE_A_LOW   = 8'h08;
    localparam logic [7:0]  OFF_SENSE_B_LOW   = 8'h09;
    localparam logic [7:0]  OFF_SENSE_C_LOW   = 8'h0a;
    localparam logic [7:0]  OFF_HAUL_HIGH     = 8'h27;
    localparam logic [7:0]  OFF_SENSE_A_HIGH  = 8'h28;
    localparam logic [7:0]  OFF_SENSE_B_HIGH  = 8'h29;
    localparam logic [7:0]  REG_RESET         = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

    // field positions inside a sensitivity register
    localparam int unsigned ODD_CODE_LSB      = 0;
    localparam int unsigned ODD_RATIO_BIT     = 3;
    localparam int unsigned EVEN_CODE_LSB     = 4;
    localparam int unsigned EVEN_RATIO_BIT    = 7;

    // register indices
    localparam logic [2:0]  IDX_HAUL_LOW      = 3'h0;
    localparam logic [2:0]  IDX_SENSE_A_LOW   = 3'h1;
    localparam logic [2:0]  IDX_SENSE_B_LOW   = 3'h2;
    localparam logic [2:0]  IDX_SENSE_C_LOW   = 3'h3;
    localparam logic [2:0]  IDX_HAUL_HIGH     = 3'h4;
    localparam logic [2:0]  IDX_SENSE_A_HIGH  = 3'h5;
    localparam logic [2:0]  IDX_SENSE_B_HIGH  = 3'h6;

    // ----------------------------------------------------------------
    // master clock figures, kHz
    // ----------------------------------------------------------------
    localparam logic [14:0] KHZ_T1_BASE       = 15'h0608;  // 1544
    localparam logic [14:0] KHZ_E1_BASE       = 15'h0800;  // 2048

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LMSC_MODE_T1     = 2'b00,
        LMSC_MODE_E1     = 2'b01,
        LMSC_MODE_EITHER = 2'b10
    } lmsc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } lmsc_req_t;

    typedef struct packed {
        logic [15:0] longHaul;
        logic [15:0] rxRatio1to1;
        logic [47:0] rxSensitivityCode;
    } lmsc_chan_t;

    typedef struct packed {
        logic        pllOn;
        logic        clockFamilySelect;
        logic [1:0]  clockPeriodSelect;
        logic        mclkIsE1Rate;
    } lmsc_clk_cfg_t;

    typedef struct packed {
        logic        pllActive;
        logic [14:0] mclkKhz;
        lmsc_mode_t  mode;
    } lmsc_clk_sel_t;

endpackage

// [sim/lmsc_config_bank_tb.sv]
// self-checking bench for the line mode and sensitivity configuration bank
`timescale 1ns/100ps
module lmsc_config_bank_tb;
    import lmsc_pkg::*;

    // ----------------------------------------------------------------
    // signals and bench state
    // ----------------------------------------------------------------
    localparam int  LIMIT = 2000;
    logic           sys_clk;
    logic           reset_n;
    lmsc_req_t      hostReq;
    logic [7:0]     hostRdData;
    logic           hostRdValid;
    lmsc_clk_cfg_t  clkCfg;
    lmsc_chan_t     chanCfg;
    lmsc_clk_sel_t  clkSel;
    int             mismatches;
    int             checks;
    int             cycles;
    logic [7:0]     img [7];
    logic [7:0]     offs [7];

    lmsc_config_bank u_dut
    (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .hostReq     (hostReq),
        .hostRdData  (hostRdData),
        .hostRdValid (hostRdValid),
        .clkCfg      (clkCfg),
        .chanCfg     (chanCfg),
        .clkSel      (clkSel)
    );

    // clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            mismatches++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] expv);
        checks++;
        if (seen !== expv)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // strobe stays high across back-to-back calls; idle drops it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        hostReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    endtask

    task automatic idle();
        @(negedge sys_clk);
        hostReq.wr = 1'b0;
        hostReq.rd = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] expv);
        @(negedge sys_clk);
        hostReq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge sys_clk);
        hostReq.rd = 1'b0;
        check("read valid", hostRdValid, 1'b1);
        check("read data", hostRdData, expv);
    endtask

    // expected channel outputs from the register image
    function automatic lmsc_chan_t exp_chan();
        lmsc_chan_t e;
        int         r;
        logic [7:0] v;
        logic [3:0] n;
        e = '0;
        e.longHaul = {img[4], img[0]};
        for (int ch = 0; ch < 16; ch++)
        begin
            r = (ch < 6) ? 1 + ch / 2 : ((ch >= 8 && ch < 12) ? 5 + (ch - 8) / 2 : -1);
            v = (r < 0) ? 8'h00 : img[r];
            n = (ch % 2 == 1) ? v[7:4] : v[3:0];
            e.rxRatio1to1[ch] = n[3];
            e.rxSensitivityCode[3 * ch +: 3] = n[2:0];
        end
        return e;
    endfunction

    // expected master clock in kHz, straight from the selection table
    function automatic logic [14:0] exp_khz(input lmsc_clk_cfg_t c);
        logic [14:0] t1Rates [4];
        logic [14:0] e1Rates [4];
        t1Rates = '{15'h0608, 15'h0c10, 15'h1820, 15'h3040};
        e1Rates = '{15'h0800, 15'h1000, 15'h2000, 15'h4000};
        if (!c.pllOn)
            return c.mclkIsE1Rate ? 15'h0800 : 15'h0608;
        return c.clockFamilySelect ? t1Rates[c.clockPeriodSelect]
                                   : e1Rates[c.clockPeriodSelect];
    endfunction

    task automatic all_regs();
        for (int i = 0; i < 7; i++)
            rd_chk(offs[i], img[i]);
        check("channel outputs", chanCfg, exp_chan());
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        offs = '{OFF_HAUL_LOW, OFF_SENSE_A_LOW, OFF_SENSE_B_LOW, OFF_SENSE_C_LOW,
                 OFF_HAUL_HIGH, OFF_SENSE_A_HIGH, OFF_SENSE_B_HIGH};
        img = '{default: 8'h00};
        hostReq = '0;
        clkCfg = '0;
        mismatches = 0;
        checks = 0;
        cycles = 0;
        reset_n = 1'b0;
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        // defaults after reset
        all_regs();
        // back-to-back writes of a pattern and its inverse
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 7; i++)
            begin
                img[i] = 8'(8'ha5 ^ (i * 8'h13)) ^ {8{p[0]}};
                wr_reg(offs[i], img[i]);
            end
            idle();
            all_regs();
        end
        // unmapped offsets ignore writes and read zero
        wr_reg(8'h0b, 8'hff);
        wr_reg(8'h26, 8'hff);
        wr_reg(8'h2a, 8'hff);
        idle();
        rd_chk(8'h2a, UNMAPPED_READ);
        rd_chk(8'h0b, UNMAPPED_READ);
        all_regs();
        // read and write together return the old value; valid lasts one cycle
        @(negedge sys_clk);
        hostReq = '{addr: OFF_HAUL_LOW, wr: 1'b1, rd: 1'b1, wdata: 8'h3c};
        @(negedge sys_clk);
        hostReq.wr = 1'b0;
        hostReq.rd = 1'b0;
        check("old data", hostRdData, img[0]);
        img[0] = 8'h3c;
        @(negedge sys_clk);
        check("valid drop", hostRdValid, 1'b0);
        check("held data", hostRdData, 8'h5a ^ 8'hff ^ 8'hff ^ 8'h5a ^ 8'h5a);
        rd_chk(OFF_HAUL_LOW, 8'h3c);
        // clock selection decode over every setting
        for (int k = 0; k < 32; k++)
        begin
            @(negedge sys_clk);
            clkCfg = lmsc_clk_cfg_t'(k[4:0]);
            #1;
            check("loop active", clkSel.pllActive, clkCfg.pllOn);
            check("mclk khz", clkSel.mclkKhz, exp_khz(clkCfg));
            check("mode", clkSel.mode, clkCfg.pllOn ? LMSC_MODE_EITHER :
                (clkCfg.mclkIsE1Rate ? LMSC_MODE_E1 : LMSC_MODE_T1));
        end
        // reset in mid-run clears everything
        @(negedge sys_clk);
        reset_n = 1'b0;
        #1;
        img = '{default: 8'h00};
        check("reset channels", chanCfg, exp_chan());
        check("reset read data", hostRdData, 8'h00);
        check("reset read valid", hostRdValid, 1'b0);
        @(negedge sys_clk);
        reset_n = 1'b1;
        all_regs();
        // software sets the ratio bit on long-haul channel one and on
        // short-haul channel two
        img[0] = 8'h01;
        wr_reg(OFF_HAUL_LOW, img[0]);
        img[1] = 8'h88;
        wr_reg(OFF_SENSE_A_LOW, img[1]);
        idle();
        all_regs();
        give_verdict();
    end
endmodule
